// [design/pfmb_defines.svh]
// Constants for the pad function multiplexer and boot strap capture
`ifndef PFMB_DEFINES_SVH
`define PFMB_DEFINES_SVH

`define PFMB_NPAD        31
`define PFMB_NGPIO       38
`define PFMB_NPHYPAD     16
`define PFMB_SEL_NORM    2'b00
`define PFMB_SEL_GPIO    2'b01
`define PFMB_SEL_ALT     2'b10
`define PFMB_SEL_ALT2    2'b11
`define PFMB_PHY_DIGITAL 2'b11
// General-purpose line for each pad, listed from the last pad down to pad 0
`define PFMB_GPIO_LINES  '{6'h11, 6'h10, 6'h0f, 6'h0e, 6'h13, 6'h12, 6'h15, 6'h14, \
                           6'h1d, 6'h1c, 6'h1b, 6'h1a, 6'h19, 6'h18, 6'h17, 6'h16, \
                           6'h03, 6'h02, 6'h01, 6'h00, 6'h05, 6'h04, 6'h06, 6'h0a, \
                           6'h09, 6'h08, 6'h07, 6'h0b, 6'h0d, 6'h0c, 6'h25}
`define PFMB_DBG_DEFAULT  1'b1
`define PFMB_TEST_DEFAULT 1'b0
`define PFMB_PCM_SLOT_KHZ 64

`endif

// [design/pfmb_pkg.sv]
// Types shared by the pad function multiplexer
package pfmb_pkg;
  `include "pfmb_defines.svh"

  // Pad order; the phy pads from PAD_P3TP onward form one contiguous run
  typedef enum logic [4:0] {
    PAD_REF, PAD_S0TX, PAD_S0RX, PAD_GP0, PAD_SCLK, PAD_MOSI, PAD_MISO, PAD_CS0,
    PAD_CS1, PAD_SCL, PAD_SDA, PAD_SDI, PAD_SDO, PAD_WS, PAD_I2SCLK,
    PAD_P3TP, PAD_P3TN, PAD_P3RP, PAD_P3RN, PAD_P4RP, PAD_P4RN, PAD_P4TP, PAD_P4TN,
    PAD_P2TP, PAD_P2TN, PAD_P2RP, PAD_P2RN, PAD_P1TP, PAD_P1TN, PAD_P1RP, PAD_P1RN
  } pfmb_pad_t;

  typedef struct packed {
    logic [`PFMB_NPAD-1:0] val;
    logic [`PFMB_NPAD-1:0] oe;
  } pfmb_drv_t;

  typedef struct packed {
    logic [`PFMB_NGPIO-1:0] val;
    logic [`PFMB_NGPIO-1:0] oe;
  } pfmb_gpio_t;

  typedef struct packed {
    logic       clk;
    logic       cmdVal;
    logic       cmdOe;
    logic [7:0] dataVal;
    logic [7:0] dataOe;
  } pfmb_card_t;

  typedef struct packed {
    logic tx;
    logic clkVal;
    logic clkOe;
    logic fsVal;
    logic fsOe;
  } pfmb_pcm_t;

  typedef struct packed {
    logic [`PFMB_NPAD-1:0]  func;
    logic [`PFMB_NGPIO-1:0] gpio;
    logic                   pcmRx;
    logic                   pcm_bit_clock;
    logic                   pcm_frame_sync;
    logic                   cardWp;
    logic                   cardDetect;
    logic                   cardCmd;
    logic [7:0]             cardData;
    logic                   serial2Rx;
  } pfmb_in_t;

  typedef struct packed {
    logic       refclk;
    logic       serial0;
    logic       spi;
    logic [1:0] gp0;
    logic [1:0] cs1;
    logic [1:0] i2c;
    logic [1:0] i2s;
    logic [1:0] card;
    logic [1:0] serial2;
    logic [1:0] pulse0;
    logic [1:0] pulse1;
    logic [1:0] spiSlave;
    logic [4:1] analogEnable;
  } pfmb_sel_t;

  typedef struct packed {
    logic       ledNotJtag;
    logic       crystal40;
    logic       dramDdr1;
    logic [2:0] bootMode;
    logic       testMode;
  } pfmb_strap_t;
endpackage : pfmb_pkg

// [design/pfmb_pad_function_mux_bootstrap.sv]
// Pad function multiplexer with boot strap capture
`timescale 1ns/100ps
`include "pfmb_defines.svh"

// What this block does
// - Reference clock pad carries reference clock at select 0, general line 37 at 1.
// - Serial 0 pads carry serial port 0 at 0, general lines 12 and 13 at 1.
// - General pad: 00/01 line 11, 10 reference clock, 11 PCIe device reset.
// - SPI pads carry SPI at 0; at 1 output lines 7,8 and lines 9,10.
// - Second chip select pad: 00 chip select 1, 01 line 6, 10 reference clock.
// - I2C pads: 00 I2C controller, 01 general lines 4 and 5.
// - Audio pads: 00 I2S, 01 lines 0-3, 10 PCM receive, transmit, clock, sync.
// - Phy 3/4 pads analog unless enabled; then card 00 card, 01 lines 22-29.
// - Card order: write protect, detect, D1, D0, clock, command, D3, D2.
// - Phy 2 transmit pads: serial 2, lines 20/21, pulse 2/3, card D5/D4.
// - Phy 2 receive positive: pulse 0, line 18, or card data 7.
// - Phy 2 receive negative: pulse 1, line 19, or card data 6.
// - Phy 1 pads: SPI slave, lines 14-17, or pulse 0/1 and serial 2.
// - PCM clock driven here or outside, 64 kHz per slot, 256 kHz to 8.192 MHz.
// - PCM frame sync direction is set apart from PCM clock direction.
// - PCM transmit data drives out; PCM receive data is an input.
// - Debug strap on serial 1 receive: 0 JTAG on LEDs, 1 LED use.
// - Crystal strap on PCIe reset pad: 0 is 25 MHz, 1 is 40 MHz.
// - Memory strap on I2S data out: 1 DDR1, 0 DDR2; small package pulls low.
// - Boot mode vector from MOSI, SPI clock, chip select 1 straps.
// - Test strap on serial 0 transmit pad: 1 test mode, 0 normal.
// - Every general line comes out of reset as an input.
module pfmb_pad_function_mux_bootstrap (
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire pfmb_pkg::pfmb_sel_t    sel,
  input  wire pfmb_pkg::pfmb_drv_t    funcDrv,
  input  wire pfmb_pkg::pfmb_gpio_t   gpioDrv,
  input  wire logic                   refclkOut,
  input  wire logic                   pcieReset,
  input  wire pfmb_pkg::pfmb_pcm_t    pcmDrv,
  input  wire pfmb_pkg::pfmb_card_t   cardDrv,
  input  wire logic [3:0]             pulse,
  input  wire logic                   serial2Tx,
  input  wire logic [`PFMB_NPAD-1:0]  padIn,
  input  wire logic                   serial1ReceivePad,
  input  wire logic                   pcieResetPad,
  output logic [`PFMB_NPAD-1:0]       padOut,
  output logic [`PFMB_NPAD-1:0]       padOe,
  output pfmb_pkg::pfmb_in_t          periphIn,
  output pfmb_pkg::pfmb_strap_t       strap,
  output logic                        strapValid
);
  import pfmb_pkg::*;

  // Descending range so the pattern, written last pad first, lands on the right pads
  localparam logic [5:0] LINE [`PFMB_NPAD-1:0] = `PFMB_GPIO_LINES;

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  logic [`PFMB_NPAD+1:0] padS1_q;
  logic [`PFMB_NPAD+1:0] padS2_q;
  logic [`PFMB_NPAD-1:0] padS;
  pfmb_drv_t             drv_d;
  pfmb_drv_t             drv_q;
  pfmb_in_t              in_d;
  pfmb_in_t              in_q;
  logic [`PFMB_NPAD-1:0] useGpio;
  pfmb_strap_t           strap_q;
  logic                  strapDone_q;

  // Pads are asynchronous to clk; no reset so straps settle during reset
  always_ff @(posedge clk) begin
    padS1_q <= {serial1ReceivePad, pcieResetPad, padIn};
    padS2_q <= padS1_q;
  end
  assign padS = padS2_q[`PFMB_NPAD-1:0];

  // ----------------------------------------------------------------
  // Function select
  // ----------------------------------------------------------------
  // Later assignments override earlier ones; unused codes leave pads undriven
  always_comb begin
    drv_d    = funcDrv;
    drv_d.oe[PAD_P3TP +: `PFMB_NPHYPAD] = '0; // Phy pads stay analog by default
    useGpio  = '0;
    in_d     = '0;
    in_d.func = padS;
    if (sel.refclk) begin
      useGpio[PAD_REF] = 1'b1;
    end else begin
      drv_d.val[PAD_REF] = refclkOut;
      drv_d.oe[PAD_REF]  = 1'b1;
    end
    if (sel.serial0) begin
      useGpio[PAD_S0TX] = 1'b1;
      useGpio[PAD_S0RX] = 1'b1;
    end
    case (sel.gp0)
      `PFMB_SEL_ALT:  begin
        drv_d.val[PAD_GP0] = refclkOut;
        drv_d.oe[PAD_GP0]  = 1'b1;
      end
      `PFMB_SEL_ALT2: begin
        drv_d.val[PAD_GP0] = pcieReset;
        drv_d.oe[PAD_GP0]  = 1'b1;
      end
      default:        useGpio[PAD_GP0] = 1'b1;
    endcase
    if (sel.spi) begin
      useGpio[PAD_CS0:PAD_SCLK] = '1;
    end
    case (sel.cs1)
      `PFMB_SEL_GPIO: useGpio[PAD_CS1] = 1'b1;
      `PFMB_SEL_ALT:  begin
        drv_d.val[PAD_CS1] = refclkOut;
        drv_d.oe[PAD_CS1]  = 1'b1;
      end
      `PFMB_SEL_ALT2: drv_d.oe[PAD_CS1] = 1'b0;
      default:        ;
    endcase
    case (sel.i2c)
      `PFMB_SEL_NORM: ;
      `PFMB_SEL_GPIO: useGpio[PAD_SDA:PAD_SCL] = '1;
      default:        drv_d.oe[PAD_SDA:PAD_SCL] = '0;
    endcase
    case (sel.i2s)
      `PFMB_SEL_NORM: ;
      `PFMB_SEL_GPIO: useGpio[PAD_I2SCLK:PAD_SDI] = '1;
      `PFMB_SEL_ALT:  begin
        drv_d.oe[PAD_SDI]     = 1'b0;
        in_d.pcmRx            = padS[PAD_SDI];
        drv_d.val[PAD_SDO]    = pcmDrv.tx;
        drv_d.oe[PAD_SDO]     = 1'b1;
        // Clock and sync directions are independent; 8.192 MHz is well below clk
        drv_d.val[PAD_WS]     = pcmDrv.clkVal;
        drv_d.oe[PAD_WS]      = pcmDrv.clkOe;
        in_d.pcm_bit_clock           = padS[PAD_WS];
        drv_d.val[PAD_I2SCLK] = pcmDrv.fsVal;
        drv_d.oe[PAD_I2SCLK]  = pcmDrv.fsOe;
        in_d.pcm_frame_sync            = padS[PAD_I2SCLK];
      end
      default:        drv_d.oe[PAD_I2SCLK:PAD_SDI] = '0;
    endcase
    // Card group needs both phy 3 and phy 4 released from analog
    if (sel.analogEnable[4:3] == `PFMB_PHY_DIGITAL) begin
      if (sel.card == `PFMB_SEL_GPIO) begin
        useGpio[PAD_P4TN:PAD_P3TP] = '1;
      end else if (sel.card == `PFMB_SEL_NORM) begin
        in_d.cardWp          = padS[PAD_P3TP];
        in_d.cardDetect      = padS[PAD_P3TN];
        drv_d.val[PAD_P3RP]  = cardDrv.dataVal[1];
        drv_d.oe[PAD_P3RP]   = cardDrv.dataOe[1];
        drv_d.val[PAD_P3RN]  = cardDrv.dataVal[0];
        drv_d.oe[PAD_P3RN]   = cardDrv.dataOe[0];
        drv_d.val[PAD_P4RP]  = cardDrv.clk;
        drv_d.oe[PAD_P4RP]   = 1'b1;
        drv_d.val[PAD_P4RN]  = cardDrv.cmdVal;
        drv_d.oe[PAD_P4RN]   = cardDrv.cmdOe;
        in_d.cardCmd         = padS[PAD_P4RN];
        drv_d.val[PAD_P4TP]  = cardDrv.dataVal[3];
        drv_d.oe[PAD_P4TP]   = cardDrv.dataOe[3];
        drv_d.val[PAD_P4TN]  = cardDrv.dataVal[2];
        drv_d.oe[PAD_P4TN]   = cardDrv.dataOe[2];
        in_d.cardData[3:0]   = {padS[PAD_P4TP], padS[PAD_P4TN], padS[PAD_P3RP],
                                padS[PAD_P3RN]};
      end
    end
    if (sel.analogEnable[2]) begin
      case (sel.serial2)
        `PFMB_SEL_NORM: begin
          drv_d.val[PAD_P2TP] = serial2Tx;
          drv_d.oe[PAD_P2TP]  = 1'b1;
          in_d.serial2Rx      = padS[PAD_P2TN];
        end
        `PFMB_SEL_GPIO: useGpio[PAD_P2TN:PAD_P2TP] = '1;
        `PFMB_SEL_ALT:  begin
          drv_d.val[PAD_P2TN:PAD_P2TP] = pulse[3:2];
          drv_d.oe[PAD_P2TN:PAD_P2TP]  = '1;
        end
        `PFMB_SEL_ALT2: begin
          drv_d.val[PAD_P2TP] = cardDrv.dataVal[5];
          drv_d.oe[PAD_P2TP]  = cardDrv.dataOe[5];
          drv_d.val[PAD_P2TN] = cardDrv.dataVal[4];
          drv_d.oe[PAD_P2TN]  = cardDrv.dataOe[4];
          in_d.cardData[5:4]  = {padS[PAD_P2TP], padS[PAD_P2TN]};
        end
      endcase
      case (sel.pulse0)
        `PFMB_SEL_NORM: begin
          drv_d.val[PAD_P2RP] = pulse[0];
          drv_d.oe[PAD_P2RP]  = 1'b1;
        end
        `PFMB_SEL_GPIO: useGpio[PAD_P2RP] = 1'b1;
        `PFMB_SEL_ALT2: begin
          drv_d.val[PAD_P2RP] = cardDrv.dataVal[7];
          drv_d.oe[PAD_P2RP]  = cardDrv.dataOe[7];
          in_d.cardData[7]    = padS[PAD_P2RP];
        end
        default:        ;
      endcase
      case (sel.pulse1)
        `PFMB_SEL_NORM: begin
          drv_d.val[PAD_P2RN] = pulse[1];
          drv_d.oe[PAD_P2RN]  = 1'b1;
        end
        `PFMB_SEL_GPIO: useGpio[PAD_P2RN] = 1'b1;
        `PFMB_SEL_ALT2: begin
          drv_d.val[PAD_P2RN] = cardDrv.dataVal[6];
          drv_d.oe[PAD_P2RN]  = cardDrv.dataOe[6];
          in_d.cardData[6]    = padS[PAD_P2RN];
        end
        default:        ;
      endcase
    end
    if (sel.analogEnable[1]) begin
      case (sel.spiSlave)
        `PFMB_SEL_NORM: begin
          drv_d.val[PAD_P1RN:PAD_P1TP] = funcDrv.val[PAD_P1RN:PAD_P1TP];
          drv_d.oe[PAD_P1RN:PAD_P1TP]  = funcDrv.oe[PAD_P1RN:PAD_P1TP];
        end
        `PFMB_SEL_GPIO: useGpio[PAD_P1RN:PAD_P1TP] = '1;
        `PFMB_SEL_ALT2: begin
          drv_d.val[PAD_P1RP:PAD_P1TP] = {serial2Tx, pulse[1:0]};
          drv_d.oe[PAD_P1RP:PAD_P1TP]  = '1;
          in_d.serial2Rx               = padS[PAD_P1RN];
        end
        default:        ;
      endcase
    end
    // General-purpose routing follows the GPIO controller's own direction, except SPI output lines 7 and 8
    for (int p = 0; p < `PFMB_NPAD; p++) begin
      if (useGpio[p]) begin
        drv_d.val[p]        = gpioDrv.val[LINE[p]];
        drv_d.oe[p]         = gpioDrv.oe[LINE[p]];
        in_d.gpio[LINE[p]]  = padS[p];
      end
    end
    if (sel.spi) begin
      drv_d.oe[PAD_MOSI:PAD_SCLK] = '1;
    end
  end

  // ----------------------------------------------------------------
  // Pad and peripheral registers
  // ----------------------------------------------------------------
  // Reset leaves every pad undriven so all lines start as inputs
  always_ff @(posedge clk) begin
    if (srst) begin
      drv_q <= '0;
    end else begin
      drv_q <= drv_d;
    end
  end

  // Peripheral inputs registered so no consumer sees mux glitches
  always_ff @(posedge clk) begin
    if (srst) begin
      in_q <= '0;
    end else begin
      in_q <= in_d;
    end
  end

  // ----------------------------------------------------------------
  // Boot straps
  // ----------------------------------------------------------------
  // Pads float as inputs in reset, so the first cycle after release sees straps
  always_ff @(posedge clk) begin
    if (srst) begin
      strap_q            <= '0;
      strap_q.ledNotJtag <= `PFMB_DBG_DEFAULT;
      strap_q.testMode   <= `PFMB_TEST_DEFAULT;
      strapDone_q        <= 1'b0;
    end else if (!strapDone_q) begin
      strap_q.ledNotJtag <= padS2_q[`PFMB_NPAD+1];
      strap_q.crystal40  <= padS2_q[`PFMB_NPAD];
      strap_q.dramDdr1   <= padS[PAD_SDO];
      strap_q.bootMode   <= {padS[PAD_MOSI], padS[PAD_SCLK], padS[PAD_CS1]};
      strap_q.testMode   <= padS[PAD_S0TX];
      strapDone_q        <= 1'b1;
    end
  end

  assign padOut     = drv_q.val;
  assign padOe      = drv_q.oe;
  assign periphIn   = in_q;
  assign strap      = strap_q;
  assign strapValid = strapDone_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence sRelease;
    srst ##1 !srst;
  endsequence

  a_refclk_route: assert property (
    !sel.refclk |=> padOe[PAD_REF] && padOut[PAD_REF] == $past(refclkOut))
    else $error("reference clock pad not driven by reference clock");
  a_serial0_gpio: assert property (
    sel.serial0 |=> padOe[PAD_S0TX] == $past(gpioDrv.oe[12]))
    else $error("serial 0 transmit pad not following line 12");
  a_gp0_perst: assert property (
    sel.gp0 == `PFMB_SEL_ALT2 |=> padOe[PAD_GP0] && padOut[PAD_GP0] == $past(pcieReset))
    else $error("general pad not driving PCIe reset");
  a_spi_gpo: assert property (
    sel.spi |=> padOe[PAD_SCLK] && padOut[PAD_MOSI] == $past(gpioDrv.val[8]))
    else $error("SPI pads not output lines in GPIO mode");
  a_cs1_refclk: assert property (
    sel.cs1 == `PFMB_SEL_ALT |=> padOut[PAD_CS1] == $past(refclkOut))
    else $error("second chip select pad not reference clock");
  a_i2c_gpio: assert property (
    sel.i2c == `PFMB_SEL_GPIO |=> padOut[PAD_SDA] == $past(gpioDrv.val[5]))
    else $error("I2C data pad not following line 5");
  a_pcm_tx: assert property (
    sel.i2s == `PFMB_SEL_ALT |=> padOe[PAD_SDO] && !padOe[PAD_SDI]
      && padOut[PAD_SDO] == $past(pcmDrv.tx))
    else $error("PCM transmit pad wrong");
  a_phy_analog: assert property (
    sel.analogEnable == 4'h0 |=> padOe[PAD_P1RN:PAD_P3TP] == '0)
    else $error("phy pad driven while analog");
  a_reset_input: assert property (@(posedge clk) disable iff (1'b0)
    srst |=> padOe == '0)
    else $error("pad driven after reset");
  a_strap_capture: assert property (@(posedge clk) disable iff (1'b0)
    sRelease |=> strapValid && strap.testMode == $past(padS[PAD_S0TX]))
    else $error("test strap not captured at release");
  a_strap_hold: assert property (
    strapValid |=> $stable(strap) && strapValid)
    else $error("strap values changed after capture");
endmodule : pfmb_pad_function_mux_bootstrap

// [bench/pfmb_pad_model.sv]
// Board model of the shared pads: chip drive, outside parties and pulls
`timescale 1ns/100ps
`include "pfmb_defines.svh"

module pfmb_pad_model #(
  parameter logic [`PFMB_NPAD-1:0] PULL_UP = '0
) (
  input  wire logic [`PFMB_NPAD-1:0] padOut,
  input  wire logic [`PFMB_NPAD-1:0] padOe,
  input  wire logic [`PFMB_NPAD-1:0] extEn,
  input  wire logic [`PFMB_NPAD-1:0] extVal,
  output logic [`PFMB_NPAD-1:0]      padIn
);
  // ----------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------
  // A released pad falls to its pull, never to the last driven value
  always_comb begin
    for (int i = 0; i < `PFMB_NPAD; i++) begin
      if (padOe[i]) begin
        padIn[i] = padOut[i];
      end else if (extEn[i]) begin
        padIn[i] = extVal[i];
      end else begin
        padIn[i] = PULL_UP[i];
      end
    end
  end
endmodule : pfmb_pad_model

// [bench/pfmb_pad_function_mux_bootstrap_tb.sv]
// Self-checking bench for the pad function multiplexer and strap capture
`timescale 1ns/100ps
`include "pfmb_defines.svh"

module pfmb_pad_function_mux_bootstrap_tb;
  import pfmb_pkg::*;
  // ----------------------------------------------------------------
  // Signals and stimulus table
  // ----------------------------------------------------------------
  localparam int FN = 0, GP = 1, RC = 2, PR = 3, PU = 4, S2 = 5, TX = 6, CK = 7;
  localparam int FS = 8, CC = 9, CD = 10, CM = 11, NO = 12;
  localparam int IG = 13, IR = 14, IW = 15, ID = 16, IS = 17;
  localparam int IC = 18, IQ = 19, IM = 20, IK = 21, IU = 22;
  typedef struct {int grp; int mode; int ae; pfmb_pad_t pad; int src; int idx;} pfmb_row_t;
  logic                  clk = 1'b0;
  logic                  srst = 1'b1;
  pfmb_sel_t             sel = '0;
  pfmb_drv_t             funcDrv = '0;
  pfmb_gpio_t            gpioDrv = '0;
  logic                  refclkOut = 1'b0;
  logic                  pcieReset = 1'b0;
  pfmb_pcm_t             pcmDrv = '0;
  pfmb_card_t            cardDrv = '0;
  logic [3:0]            pulse = 4'h0;
  logic                  serial2Tx = 1'b0;
  logic                  serial1ReceivePad = 1'b1;
  logic                  pcieResetPad = 1'b0;
  logic [`PFMB_NPAD-1:0] extEn = '0;
  logic [`PFMB_NPAD-1:0] extVal = '0;
  logic [`PFMB_NPAD-1:0] padIn;
  logic [`PFMB_NPAD-1:0] padOut;
  logic [`PFMB_NPAD-1:0] padOe;
  pfmb_in_t              periphIn;
  pfmb_strap_t           strap;
  logic                  strapValid;
  int                    badCount = 0;
  int                    totalChecks = 0;
  // Each row names one source that must reach one pad, one pad that must reach an input, or a refused mode
  pfmb_row_t rows [$] = '{
    '{0,0,0,PAD_REF,RC,0}, '{0,1,0,PAD_REF,GP,37}, '{1,0,0,PAD_S0TX,FN,1},
    '{1,1,0,PAD_S0TX,GP,12}, '{1,1,0,PAD_S0RX,GP,13}, '{3,0,0,PAD_GP0,GP,11},
    '{3,1,0,PAD_GP0,GP,11}, '{3,2,0,PAD_GP0,RC,0}, '{3,3,0,PAD_GP0,PR,0},
    '{2,0,0,PAD_SCLK,FN,4}, '{2,1,0,PAD_SCLK,GP,7}, '{2,1,0,PAD_MOSI,GP,8},
    '{2,1,0,PAD_MISO,GP,9}, '{2,1,0,PAD_CS0,GP,10}, '{4,0,0,PAD_CS1,FN,8},
    '{4,1,0,PAD_CS1,GP,6}, '{4,2,0,PAD_CS1,RC,0}, '{4,3,0,PAD_CS1,NO,0},
    '{5,0,0,PAD_SCL,FN,9}, '{5,1,0,PAD_SCL,GP,4}, '{5,1,0,PAD_SDA,GP,5},
    '{6,0,0,PAD_SDO,FN,12}, '{6,1,0,PAD_SDI,GP,0}, '{6,1,0,PAD_I2SCLK,GP,3},
    '{6,2,0,PAD_SDO,TX,0}, '{6,2,0,PAD_WS,CK,0}, '{6,2,0,PAD_I2SCLK,FS,0},
    '{6,3,0,PAD_WS,NO,0}, '{6,2,0,PAD_SDI,IR,0}, '{6,1,0,PAD_SDO,IG,1},
    '{7,0,15,PAD_P4RP,CC,0}, '{7,0,15,PAD_P4RN,CM,0}, '{7,0,15,PAD_P3RN,CD,0},
    '{7,0,15,PAD_P3RP,CD,1}, '{7,0,15,PAD_P4TN,CD,2}, '{7,0,15,PAD_P4TP,CD,3},
    '{7,0,15,PAD_P3TP,IW,0}, '{7,0,15,PAD_P3TN,ID,0}, '{7,1,15,PAD_P3TP,GP,22},
    '{7,1,15,PAD_P4TN,GP,29}, '{7,1,15,PAD_P4RP,IG,26}, '{7,1,0,PAD_P3TP,NO,0},
    '{7,0,8,PAD_P4RP,NO,0}, '{8,0,2,PAD_P2TP,S2,0}, '{8,0,2,PAD_P2TN,IS,0},
    '{8,1,2,PAD_P2TP,GP,20}, '{8,1,2,PAD_P2TN,GP,21}, '{8,2,2,PAD_P2TP,PU,2},
    '{8,2,2,PAD_P2TN,PU,3}, '{8,3,2,PAD_P2TP,CD,5}, '{8,3,2,PAD_P2TN,CD,4},
    '{9,0,2,PAD_P2RP,PU,0}, '{9,1,2,PAD_P2RP,GP,18}, '{9,3,2,PAD_P2RP,CD,7},
    '{9,2,2,PAD_P2RP,NO,0}, '{10,0,2,PAD_P2RN,PU,1}, '{10,1,2,PAD_P2RN,GP,19},
    '{10,3,2,PAD_P2RN,CD,6}, '{11,0,1,PAD_P1RP,FN,29}, '{11,1,1,PAD_P1TP,GP,14},
    '{11,1,1,PAD_P1RN,GP,17}, '{11,3,1,PAD_P1TP,PU,0}, '{11,3,1,PAD_P1TN,PU,1},
    '{11,3,1,PAD_P1RP,S2,0}, '{11,2,1,PAD_P1TP,NO,0}, '{8,2,0,PAD_P2TP,NO,0},
    '{6,2,0,PAD_WS,IC,0}, '{6,2,0,PAD_I2SCLK,IQ,0}, '{7,0,15,PAD_P4RN,IM,0},
    '{7,0,15,PAD_P4TP,IK,3}, '{8,3,2,PAD_P2TP,IK,5}, '{9,3,2,PAD_P2RP,IK,7},
    '{11,3,1,PAD_P1RN,IS,0}, '{0,0,0,PAD_S0RX,IU,2}};
  logic [6:0] straps [6] = '{7'h00, 7'h7f, 7'h03, 7'h45, 7'h26, 7'h58};

  // ----------------------------------------------------------------
  // Clock, instances
  // ----------------------------------------------------------------
  always #2.5 clk = ~clk;

  pfmb_pad_function_mux_bootstrap pfmb_pad_function_mux_bootstrap_inst (
    .clk(clk), .srst(srst), .sel(sel), .funcDrv(funcDrv), .gpioDrv(gpioDrv),
    .refclkOut(refclkOut), .pcieReset(pcieReset), .pcmDrv(pcmDrv), .cardDrv(cardDrv),
    .pulse(pulse), .serial2Tx(serial2Tx), .padIn(padIn),
    .serial1ReceivePad(serial1ReceivePad), .pcieResetPad(pcieResetPad),
    .padOut(padOut), .padOe(padOe), .periphIn(periphIn), .strap(strap),
    .strapValid(strapValid));

  pfmb_pad_model pfmb_pad_model_inst (
    .padOut(padOut), .padOe(padOe), .extEn(extEn), .extVal(extVal), .padIn(padIn));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Inputs always move 1 ns after the edge so no race with the design
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Input rows release every drive so the outside party owns the pad
  task automatic apply(input pfmb_row_t r, input logic v);
    logic oe;
    oe = (r.src < IG);
    sel = '0;
    sel.analogEnable = 4'(r.ae);
    case (r.grp)
      0: sel.refclk = r.mode[0];
      1: sel.serial0 = r.mode[0];
      2: sel.spi = r.mode[0];
      3: sel.gp0 = 2'(r.mode);
      4: sel.cs1 = 2'(r.mode);
      5: sel.i2c = 2'(r.mode);
      6: sel.i2s = 2'(r.mode);
      7: sel.card = 2'(r.mode);
      8: sel.serial2 = 2'(r.mode);
      9: sel.pulse0 = 2'(r.mode);
      10: sel.pulse1 = 2'(r.mode);
      default: sel.spiSlave = 2'(r.mode);
    endcase
    funcDrv = '{val: '0, oe: {`PFMB_NPAD{oe}}};
    gpioDrv = '{val: '0, oe: {`PFMB_NGPIO{oe}}};
    refclkOut = 1'b0;
    pcieReset = 1'b0;
    pcmDrv = '{tx: 1'b0, clkVal: 1'b0, clkOe: oe, fsVal: 1'b0, fsOe: oe};
    cardDrv = '{clk: 1'b0, cmdVal: 1'b0, cmdOe: oe, dataVal: 8'h00, dataOe: {8{oe}}};
    pulse = 4'h0;
    serial2Tx = 1'b0;
    extEn = '0;
    extVal = '0;
    case (r.src)
      FN: funcDrv.val[r.idx] = v;
      GP: gpioDrv.val[r.idx] = v;
      RC: refclkOut = v;
      PR: pcieReset = v;
      PU: pulse[r.idx] = v;
      S2: serial2Tx = v;
      TX: pcmDrv.tx = v;
      CK: pcmDrv.clkVal = v;
      FS: pcmDrv.fsVal = v;
      CC: cardDrv.clk = v;
      CD: cardDrv.dataVal[r.idx] = v;
      CM: cardDrv.cmdVal = v;
      default: begin
        extEn[r.pad] = 1'b1;
        extVal[r.pad] = v;
      end
    endcase
  endtask : apply

  function automatic logic inVal(input pfmb_row_t r);
    case (r.src)
      IR: return periphIn.pcmRx;
      IW: return periphIn.cardWp;
      ID: return periphIn.cardDetect;
      IS: return periphIn.serial2Rx;
      IC: return periphIn.pcm_bit_clock;
      IQ: return periphIn.pcm_frame_sync;
      IM: return periphIn.cardCmd;
      IK: return periphIn.cardData[r.idx];
      IU: return periphIn.func[r.idx];
      default: return periphIn.gpio[r.idx];
    endcase
  endfunction : inVal

  // Reset with a strap pattern, then confirm capture and that it holds
  task automatic resetWith(input logic [6:0] s);
    apply(pfmb_row_t'{0, 0, 0, PAD_REF, IG, 0}, 1'b0);
    funcDrv.oe = '1;
    serial1ReceivePad = s[6];
    pcieResetPad = s[5];
    extEn[PAD_SDO] = 1'b1;
    extEn[PAD_MOSI] = 1'b1;
    extEn[PAD_SCLK] = 1'b1;
    extEn[PAD_CS1] = 1'b1;
    extEn[PAD_S0TX] = 1'b1;
    // Bit 12 is the I2S data-out pad that carries the memory strap
    extVal = {`PFMB_NPAD{1'b0}} | {s[4], 3'h0, s[1], 2'h0, s[3], s[2], 2'h0, s[0], 1'b0};
    srst = 1'b1;
    step(10);
    check(padOe, 32'h0);
    check({strapValid, strap}, {1'b0, 7'h40});
    funcDrv.oe = '0;
    srst = 1'b0;
    step(1);
    check({strapValid, strap}, {1'b1, s});
    extVal = ~extVal;
    serial1ReceivePad = ~s[6];
    pcieResetPad = ~s[5];
    step(5);
    check({strapValid, strap}, {1'b1, s});
  endtask : resetWith

  task automatic results;
    $display("checks %0d, mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    resetWith(7'h00);
    // Each row is driven high then low so a stuck or swapped route shows
    foreach (rows[i]) begin
      for (int v = 1; v >= 0; v--) begin
        apply(rows[i], v[0]);
        step(4);
        if (rows[i].src == NO) begin
          check(padOe[rows[i].pad], 1'b0);
        end else if (rows[i].src >= IG) begin
          check(inVal(rows[i]), v[0]);
        end else begin
          check({padOe[rows[i].pad], padOut[rows[i].pad]}, {1'b1, v[0]});
        end
      end
    end
    $display("test pad routing done");
    // Frame sync direction must not follow the clock direction
    apply(pfmb_row_t'{6, 2, 0, PAD_WS, CK, 0}, 1'b0);
    for (int k = 1; k <= 2; k++) begin
      pcmDrv.clkOe = k[0];
      pcmDrv.fsOe = k[1];
      step(2);
      check({padOe[PAD_WS], padOe[PAD_I2SCLK]}, {k[0], k[1]});
    end
    $display("test frame sync direction done");
    foreach (straps[i]) begin
      resetWith(straps[i]);
    end
    $display("test strap capture done");
    results();
  end

  // Guard against a hang
  initial begin
    #200us;
    badCount++;
    results();
  end
endmodule : pfmb_pad_function_mux_bootstrap_tb
